// ### inc/ssl_load_if.sv
// settings and live sample passed from the register bank to the load sink
// assumes both ends run on ref_clk
interface ssl_load_if;
    logic mode;
    logic [7:0] rise;
    logic [5:0] low_code;
    logic [9:0] high_code;
    logic [11:0] high_time;
    logic [7:0] sample;
    logic tick;
    ssl_pkg::ssl_level_t level;
    logic [9:0] code;
    modport ctl (
        output mode, rise, low_code, high_code, high_time, sample, tick,
        input level, code
    );
    modport load (
        input mode, rise, low_code, high_code, high_time, sample, tick,
        output level, code
    );
endinterface

// ### inc/ssl_pkg.sv
// constants, offsets and types of the status, sample and load-mode bank
// assumes one 40 MHz clock shared by every module of the bank
package ssl_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int SAMPLE_HZ = 100_000;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int TICK_US = 10;
    localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int INIT_CYC = 16;

    localparam logic [7:0] OFS_EVENT = 8'h0C;
    localparam logic [7:0] OFS_LIVE = 8'h0D;
    localparam logic [7:0] OFS_RAW = 8'h0E;
    localparam logic [7:0] OFS_DEC = 8'h0F;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_RISE = 8'h11;
    localparam logic [7:0] OFS_LOW = 8'h12;
    localparam logic [7:0] OFS_HIGH = 8'h13;
    localparam logic [7:0] OFS_HTIME = 8'h14;

    localparam int BIT_DOUT = 0;
    localparam int BIT_WARNA = 1;
    localparam int BIT_WARNB = 2;
    localparam int BIT_WARNC = 3;
    localparam int BIT_CFGFLT = 8;
    localparam int BIT_LINKFLT = 9;
    localparam int BIT_HOT = 10;
    localparam int BIT_COOL = 11;
    localparam int BIT_BUSY = 13;
    localparam int BIT_RSTDONE = 14;
    localparam logic [15:0] EVENT_MASK = 16'h6F0F;

    localparam logic [15:0] LIVE_RST = 16'h4000;
    localparam logic [15:0] EVENT_RST = 16'h0000;
    localparam logic [7:0] RAW_RST = 8'h00;
    localparam logic [7:0] DEC_RST = 8'h00;
    localparam logic MODE_RST = 1'b0;
    localparam logic [7:0] RISE_RST = 8'h1E;
    localparam logic [5:0] LOW_RST = 6'h1E;
    localparam logic [9:0] HIGH_RST = 10'h0C8;
    localparam logic [11:0] HTIME_RST = 12'h12C;
    localparam logic [7:0] RISE_MIN = 8'h01;
    localparam logic [7:0] RISE_MAX = 8'hFE;

    typedef enum logic [1:0] {
        SSL_LOAD_OFF,
        SSL_LOAD_LOW,
        SSL_LOAD_HIGH,
        SSL_LOAD_SPENT
    } ssl_level_t;
endpackage

// ### rtl/ssl_load_ctl.sv
// programmable load sink state: off, low, timed high pulse, spent
// assumes settings already clamped and tick a one-cycle 10 us pulse
module ssl_load_ctl (
    input wire logic ref_clk,
    input wire logic arst_n,
    ssl_load_if.load lif
);
    import ssl_pkg::*;

    ssl_level_t st_r, st_nxt;
    logic [11:0] tmr_r, tmr_nxt;
    logic [9:0] code_r, code_nxt;
    logic above;

    assign above = lif.sample > lif.rise;

    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        if (lif.sample == 8'h00) begin
            st_nxt = SSL_LOAD_OFF;
        end else if (lif.mode) begin
            st_nxt = SSL_LOAD_HIGH;
            tmr_nxt = lif.high_time;
        end else begin
            case (st_r)
                SSL_LOAD_HIGH: begin
                    if (!above) begin
                        st_nxt = SSL_LOAD_LOW;
                    end else if (lif.tick) begin
                        if (tmr_r <= 12'h001) begin
                            st_nxt = SSL_LOAD_SPENT;
                        end else begin
                            tmr_nxt = tmr_r - 12'h001;
                        end
                    end
                end
                SSL_LOAD_SPENT: begin
                    if (!above) begin
                        st_nxt = SSL_LOAD_LOW;
                    end
                end
                default: begin
                    if (above) begin
                        st_nxt = SSL_LOAD_HIGH;
                        tmr_nxt = lif.high_time;
                    end else begin
                        st_nxt = SSL_LOAD_LOW;
                    end
                end
            endcase
        end
        case (st_nxt)
            SSL_LOAD_OFF: code_nxt = 10'h000;
            SSL_LOAD_HIGH: code_nxt = lif.high_code;
            default: code_nxt = {4'h0, lif.low_code};
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= SSL_LOAD_OFF;
            tmr_r <= 12'h000;
            code_r <= 10'h000;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            code_r <= code_nxt;
        end
    end

    assign lif.level = st_r;
    assign lif.code = code_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_zero_off;
        lif.sample == 8'h00 |=> st_r == SSL_LOAD_OFF && code_r == 10'h000;
    endproperty
    a_zero_off: assert property (p_zero_off)
        else $error("load current not off at zero sample");

    property p_high_idle;
        lif.mode && lif.sample != 8'h00
            |=> st_r == SSL_LOAD_HIGH && code_r == $past(lif.high_code);
    endproperty
    a_high_idle: assert property (p_high_idle)
        else $error("high idle mode not drawing high current");

    property p_low_idle;
        !lif.mode && lif.sample != 8'h00 && !above
            |=> st_r == SSL_LOAD_LOW && code_r == {4'h0, $past(lif.low_code)};
    endproperty
    a_low_idle: assert property (p_low_idle)
        else $error("low idle mode not drawing low current");

    property p_rise;
        !lif.mode && above && lif.sample != 8'h00
            && (st_r == SSL_LOAD_OFF || st_r == SSL_LOAD_LOW)
            |=> st_r == SSL_LOAD_HIGH && tmr_r == $past(lif.high_time);
    endproperty
    a_rise: assert property (p_rise)
        else $error("crossing rise level did not start high current");

    property p_pulse_end;
        st_r == SSL_LOAD_HIGH && !lif.mode && above && lif.tick
            && tmr_r == 12'h001 |=> st_r == SSL_LOAD_SPENT;
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("high pulse did not end when timer ran out");

    c_pulse: cover property (st_r == SSL_LOAD_HIGH ##1 st_r == SSL_LOAD_SPENT);
    c_fall: cover property (st_r == SSL_LOAD_SPENT ##1 st_r == SSL_LOAD_LOW);
endmodule

// ### rtl/ssl_status_bank.sv
// live status, sample registers, load mode and load settings bank
// assumes a simple register port (addr, write, read) from the serial
// front end, and all inputs synchronous to ref_clk
// Operation
// - live status bits show present source levels, never latched
// - live status word is 0x4000 with all sources clear once ready
// - reset-complete bit rises from 0 to 1 when initialisation ends
// - bit 11 shows the channel thermal back-off state
// - bits 8, 9, 10 show config mismatch, link fault, overheat
// - bits 3..1 show warnings C, B, A; bit 0 output; bit 13 busy
// - raw sample in bits 7..0, refreshed at 100 kHz, upper byte zero
// - filtered sample in bits 7..0 at the decimation rate, resets zero
// - load mode bit 0 picks low or high idle; bits 15..1 read zero
// - low idle, sample above zero and not above rise: low current
// - low idle, sample above rise level: switch to high current
// - high idle: high current whenever sample is above zero
// - rise level writes clamp 0x00 to 0x01 and 0xFF to 0xFE
// - in low idle, high current lasts high-time units of 10 us, zero taken as one
// - latched event register, write one to clear, writable when locked
module ssl_status_bank (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic dev_locked,
    input wire logic [7:0] conv_sample,
    input wire logic [3:0] decimation_factor,
    input wire logic comm_busy,
    input wire logic channel_thermal_backoff,
    input wire logic load_overheat_flag,
    input wire logic isolation_link_fault,
    input wire logic config_mismatch_fault,
    input wire logic threshold_warning_a,
    input wire logic threshold_warning_b,
    input wire logic threshold_warning_c,
    input wire logic digital_output_line,
    output ssl_pkg::ssl_level_t load_sink_level,
    output logic [9:0] load_sink_code
);
    import ssl_pkg::*;

    localparam int SW = $clog2(SAMPLE_CYC);
    localparam int TW = $clog2(TICK_CYC);
    localparam int IW = $clog2(INIT_CYC);

    ssl_load_if lif ();

    logic [15:0] live;
    logic wr_cfg;
    logic [15:0] rd_val;

    // timing group: dividers and initialisation
    logic [SW-1:0] smp_cnt_r, smp_cnt_nxt;
    logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
    logic [IW-1:0] init_cnt_r, init_cnt_nxt;
    logic rst_done_r, rst_done_nxt;
    logic smp_stb, tick;

    // sample group
    logic [7:0] raw_r, raw_nxt;
    logic [7:0] dec_r, dec_nxt;
    logic [3:0] dec_cnt_r, dec_cnt_nxt;

    // register group
    logic [15:0] event_r, event_nxt;
    logic [15:0] live_q_r;
    logic mode_r, mode_nxt;
    logic [7:0] rise_r, rise_nxt;
    logic [5:0] low_r, low_nxt;
    logic [9:0] high_r, high_nxt;
    logic [11:0] htime_r, htime_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    // the word is built straight from the sources so a poll sees the
    // present level; a source glitch between polls is only in event_r
    always_comb begin
        live = 16'h0000;
        live[BIT_DOUT] = digital_output_line;
        live[BIT_WARNA] = threshold_warning_a;
        live[BIT_WARNB] = threshold_warning_b;
        live[BIT_WARNC] = threshold_warning_c;
        live[BIT_CFGFLT] = config_mismatch_fault;
        live[BIT_LINKFLT] = isolation_link_fault;
        live[BIT_HOT] = load_overheat_flag;
        live[BIT_COOL] = channel_thermal_backoff;
        live[BIT_BUSY] = comm_busy;
        live[BIT_RSTDONE] = rst_done_r;
    end

    assign smp_stb = smp_cnt_r == SW'(SAMPLE_CYC - 1);
    assign tick = tick_cnt_r == TW'(TICK_CYC - 1);

    always_comb begin
        smp_cnt_nxt = smp_stb ? '0 : smp_cnt_r + SW'(1);
        tick_cnt_nxt = tick ? '0 : tick_cnt_r + TW'(1);
        init_cnt_nxt = init_cnt_r;
        rst_done_nxt = rst_done_r;
        if (!rst_done_r) begin
            if (init_cnt_r == IW'(INIT_CYC - 1)) begin
                rst_done_nxt = 1'b1;
            end else begin
                init_cnt_nxt = init_cnt_r + IW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            smp_cnt_r <= '0;
            tick_cnt_r <= '0;
            init_cnt_r <= '0;
            rst_done_r <= 1'b0;
        end else begin
            smp_cnt_r <= smp_cnt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            init_cnt_r <= init_cnt_nxt;
            rst_done_r <= rst_done_nxt;
        end
    end

    // filtered sample keeps the newest raw value every factor+1 strobes
    always_comb begin
        raw_nxt = raw_r;
        dec_nxt = dec_r;
        dec_cnt_nxt = dec_cnt_r;
        if (smp_stb) begin
            raw_nxt = conv_sample;
            if (dec_cnt_r >= decimation_factor) begin
                dec_nxt = conv_sample;
                dec_cnt_nxt = 4'h0;
            end else begin
                dec_cnt_nxt = dec_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_r <= RAW_RST;
            dec_r <= DEC_RST;
            dec_cnt_r <= 4'h0;
        end else begin
            raw_r <= raw_nxt;
            dec_r <= dec_nxt;
            dec_cnt_r <= dec_cnt_nxt;
        end
    end

    // settings are refused while locked; the event clear never is
    assign wr_cfg = reg_wr && !dev_locked;

    always_comb begin
        mode_nxt = mode_r;
        rise_nxt = rise_r;
        low_nxt = low_r;
        high_nxt = high_r;
        htime_nxt = htime_r;
        event_nxt = event_r;
        if (reg_wr && reg_addr == OFS_EVENT) begin
            event_nxt = event_r & ~reg_wdata;
        end
        // set after clear so a same-cycle edge survives
        event_nxt = (event_nxt | (live & ~live_q_r)) & EVENT_MASK;
        if (wr_cfg && reg_addr == OFS_MODE) begin
            mode_nxt = reg_wdata[0];
        end else if (wr_cfg && reg_addr == OFS_RISE) begin
            if (reg_wdata[7:0] == 8'h00) begin
                rise_nxt = RISE_MIN;
            end else if (reg_wdata[7:0] == 8'hFF) begin
                rise_nxt = RISE_MAX;
            end else begin
                rise_nxt = reg_wdata[7:0];
            end
        end else if (wr_cfg && reg_addr == OFS_LOW) begin
            low_nxt = (reg_wdata[5:0] == 6'h00) ? 6'h01 : reg_wdata[5:0];
        end else if (wr_cfg && reg_addr == OFS_HIGH) begin
            high_nxt = (reg_wdata[9:0] == 10'h000) ? 10'h001
                                                    : reg_wdata[9:0];
        end else if (wr_cfg && reg_addr == OFS_HTIME) begin
            htime_nxt = (reg_wdata[11:0] == 12'h000) ? 12'h001
                                                      : reg_wdata[11:0];
        end
    end

    always_comb begin
        if (reg_addr == OFS_EVENT) begin
            rd_val = event_r;
        end else if (reg_addr == OFS_LIVE) begin
            rd_val = live;
        end else if (reg_addr == OFS_RAW) begin
            rd_val = {8'h00, raw_r};
        end else if (reg_addr == OFS_DEC) begin
            rd_val = {8'h00, dec_r};
        end else if (reg_addr == OFS_MODE) begin
            rd_val = {15'h0000, mode_r};
        end else if (reg_addr == OFS_RISE) begin
            rd_val = {8'h00, rise_r};
        end else if (reg_addr == OFS_LOW) begin
            rd_val = {10'h000, low_r};
        end else if (reg_addr == OFS_HIGH) begin
            rd_val = {6'h00, high_r};
        end else if (reg_addr == OFS_HTIME) begin
            rd_val = {4'h0, htime_r};
        end else begin
            rd_val = 16'h0000;
        end
        rvalid_nxt = reg_rd;
        rdata_nxt = reg_rd ? rd_val : rdata_r;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            event_r <= EVENT_RST;
            live_q_r <= 16'h0000;
            mode_r <= MODE_RST;
            rise_r <= RISE_RST;
            low_r <= LOW_RST;
            high_r <= HIGH_RST;
            htime_r <= HTIME_RST;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            event_r <= event_nxt;
            live_q_r <= live;
            mode_r <= mode_nxt;
            rise_r <= rise_nxt;
            low_r <= low_nxt;
            high_r <= high_nxt;
            htime_r <= htime_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

    assign lif.mode = mode_r;
    assign lif.rise = rise_r;
    assign lif.low_code = low_r;
    assign lif.high_code = high_r;
    assign lif.high_time = htime_r;
    assign lif.sample = raw_r;
    assign lif.tick = tick;

    ssl_load_ctl u_load (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .lif(lif)
    );

    assign load_sink_level = lif.level;
    assign load_sink_code = lif.code;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_live_poll;
        reg_rd && reg_addr == OFS_LIVE |=> reg_rvalid
            && reg_rdata == $past(live) && reg_rdata[15] == 1'b0
            && reg_rdata[12] == 1'b0 && reg_rdata[7:4] == 4'h0;
    endproperty
    a_live_poll: assert property (p_live_poll)
        else $error("live read does not show present sources");

    property p_live_idle;
        reg_rd && reg_addr == OFS_LIVE && rst_done_r
            && (live & ~16'h4000) == 16'h0000 |=> reg_rdata == LIVE_RST;
    endproperty
    a_live_idle: assert property (p_live_idle)
        else $error("idle live word is not 0x4000");

    property p_rst_done;
        $rose(rst_done_r) |-> $past(init_cnt_r) == IW'(INIT_CYC - 1);
    endproperty
    a_rst_done: assert property (p_rst_done)
        else $error("reset-complete rose at wrong time");

    property p_rst_done_hold;
        rst_done_r |=> rst_done_r;
    endproperty
    a_rst_done_hold: assert property (p_rst_done_hold)
        else $error("reset-complete fell after initialisation");

    property p_faults;
        reg_rd && reg_addr == OFS_LIVE |=>
            reg_rdata[11:8] == {$past(channel_thermal_backoff),
            $past(load_overheat_flag), $past(isolation_link_fault),
            $past(config_mismatch_fault)};
    endproperty
    a_faults: assert property (p_faults)
        else $error("fault bits do not match sources");

    property p_warn;
        reg_rd && reg_addr == OFS_LIVE |=>
            reg_rdata[3:0] == {$past(threshold_warning_c),
            $past(threshold_warning_b), $past(threshold_warning_a),
            $past(digital_output_line)}
            && reg_rdata[13] == $past(comm_busy);
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning, output or busy bits wrong");

    property p_raw;
        !smp_stb |=> $stable(raw_r) && $stable(dec_r);
    endproperty
    a_raw: assert property (p_raw)
        else $error("sample changed off the 100 kHz strobe");

    // the host leaves one idle cycle between a write and the next read
    property p_mode;
        wr_cfg && reg_addr == OFS_MODE ##1 !reg_wr
            ##1 reg_rd && reg_addr == OFS_MODE
            |=> reg_rdata == {15'h0000, $past(reg_wdata[0], 3)};
    endproperty
    a_mode: assert property (p_mode)
        else $error("load mode readback wrong");

    property p_clamp;
        wr_cfg && reg_addr == OFS_RISE && reg_wdata[7:0] == 8'hFF
            |=> rise_r == RISE_MAX;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("rise level not clamped to 0xFE");

    property p_event_set;
        reg_wr && reg_addr == OFS_EVENT && $rose(threshold_warning_a)
            |=> event_r[BIT_WARNA];
    endproperty
    a_event_set: assert property (p_event_set)
        else $error("event lost against a same-cycle clear");

    c_ready: cover property ($rose(rst_done_r));
    c_dec: cover property (smp_stb && dec_cnt_r != 4'h0);
    c_locked_clear: cover property (dev_locked && reg_wr
        && reg_addr == OFS_EVENT);
endmodule

// ### verification/ssl_host_model.sv
// host side of the register port: single word writes and reads
// assumes the bank answers a read with rvalid one cycle after the strobe
module ssl_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // requests change at the falling edge, held across the taking edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        // released data is scrambled so a stale value cannot pass
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic ok);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        // an all-ones word means the read failed, not a ready device
        ok = (reg_rvalid === 1'b1) && (reg_rdata !== 16'hFFFF);
    endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench of the status, sample and load-mode bank
// assumes the host model drives the register port and the bench the rest
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ssl_pkg::*;
    logic ref_clk, arst_n, reg_wr, reg_rd, reg_rvalid, dev_locked;
    logic [7:0] reg_addr, conv_sample;
    logic [15:0] reg_wdata, reg_rdata, src;
    logic [9:0] code;
    logic [3:0] dec_factor;
    ssl_level_t lvl;
    int error_cnt = 0;
    int checked = 0;

    ssl_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    ssl_status_bank DUT (.ref_clk(ref_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .dev_locked(dev_locked),
        .conv_sample(conv_sample), .decimation_factor(dec_factor),
        .comm_busy(src[13]), .channel_thermal_backoff(src[11]),
        .load_overheat_flag(src[10]), .isolation_link_fault(src[9]),
        .config_mismatch_fault(src[8]), .threshold_warning_a(src[1]),
        .threshold_warning_b(src[2]), .threshold_warning_c(src[3]),
        .digital_output_line(src[0]), .load_sink_level(lvl),
        .load_sink_code(code));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_lvl(string n, ssl_level_t e, ssl_level_t g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic rd_chk(string n, logic [7:0] a, logic [15:0] e);
        logic [15:0] d;
        logic ok;
        host.rd(a, d, ok);
        chk_word({n, " answer"}, 16'h0001, {15'h0000, ok});
        chk_word(n, e, d);
    endtask
    task automatic wait_lvl(ssl_level_t l, int lim, output int n);
        n = 0;
        while (lvl !== l && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic t_reset();
        rd_chk("live in init", OFS_LIVE, 16'h0000);
        repeat (INIT_CYC + 4) @(negedge ref_clk);
        rd_chk("live ready", OFS_LIVE, LIVE_RST);
        rd_chk("raw reset", OFS_RAW, 16'h0000);
        rd_chk("dec reset", OFS_DEC, 16'h0000);
        rd_chk("mode reset", OFS_MODE, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_live();
        int bits[9] = '{0, 1, 2, 3, 8, 9, 10, 11, 13};
        foreach (bits[i]) begin
            @(negedge ref_clk);
            src = 16'h0000;
            src[bits[i]] = 1'b1;
            rd_chk("live set", OFS_LIVE, LIVE_RST | src);
            @(negedge ref_clk);
            src = 16'h0000;
            rd_chk("live clear", OFS_LIVE, LIVE_RST);
        end
        // every source rose once, and the ready flag rose after reset
        rd_chk("event", OFS_EVENT, EVENT_MASK);
        dev_locked = 1'b1;
        host.wr(OFS_EVENT, 16'hFFFF);
        rd_chk("event cleared", OFS_EVENT, 16'h0000);
        // a rising source in the clearing cycle must survive the clear
        fork
            host.wr(OFS_EVENT, 16'h0002);
            begin
                @(negedge ref_clk);
                src[1] = 1'b1;
            end
        join
        rd_chk("event kept", OFS_EVENT, 16'h0002);
        src = 16'h0000;
        dev_locked = 1'b0;
        $display("test live done");
    endtask
    task automatic t_regs();
        host.wr(OFS_MODE, 16'hFFFF);
        rd_chk("mode", OFS_MODE, 16'h0001);
        dev_locked = 1'b1;
        host.wr(OFS_MODE, 16'h0000);
        rd_chk("mode locked", OFS_MODE, 16'h0001);
        dev_locked = 1'b0;
        host.wr(OFS_MODE, 16'h0000);
        rd_chk("mode low", OFS_MODE, 16'h0000);
        host.wr(OFS_LIVE, 16'h0F0F);
        rd_chk("live write", OFS_LIVE, LIVE_RST);
        rd_chk("unmapped", 8'h20, 16'h0000);
        host.wr(OFS_RISE, 16'h0000);
        rd_chk("rise min", OFS_RISE, {8'h00, RISE_MIN});
        host.wr(OFS_RISE, 16'h00FF);
        rd_chk("rise max", OFS_RISE, {8'h00, RISE_MAX});
        host.wr(OFS_RISE, 16'h001E);
        $display("test registers done");
    endtask
    task automatic t_load();
        int n;
        host.wr(OFS_LOW, 16'h0005);
        host.wr(OFS_HIGH, 16'h00AA);
        host.wr(OFS_HTIME, 16'h0000);
        rd_chk("htime zero", OFS_HTIME, 16'h0001);
        dec_factor = 4'h1;
        conv_sample = 8'h10;
        wait_lvl(SSL_LOAD_LOW, SAMPLE_CYC + 4, n);
        chk_lvl("low level", SSL_LOAD_LOW, lvl);
        chk_word("low code", 16'h0005, {6'h00, code});
        // factor one: the filtered value waits for the second strobe
        rd_chk("dec held", OFS_DEC, 16'h0000);
        repeat (SAMPLE_CYC) @(negedge ref_clk);
        rd_chk("raw", OFS_RAW, 16'h0010);
        rd_chk("dec", OFS_DEC, 16'h0010);
        conv_sample = 8'h30;
        wait_lvl(SSL_LOAD_HIGH, SAMPLE_CYC + 4, n);
        chk_lvl("rise level", SSL_LOAD_HIGH, lvl);
        chk_word("high code", 16'h00AA, {6'h00, code});
        // a zero period counts as one tick, so the pulse ends in a tick
        wait_lvl(SSL_LOAD_SPENT, TICK_CYC + 4, n);
        chk_lvl("pulse end", SSL_LOAD_SPENT, lvl);
        chk_word("spent code", 16'h0005, {6'h00, code});
        conv_sample = 8'h00;
        wait_lvl(SSL_LOAD_OFF, SAMPLE_CYC + 4, n);
        chk_lvl("zero low idle", SSL_LOAD_OFF, lvl);
        chk_word("zero code", 16'h0000, {6'h00, code});
        host.wr(OFS_MODE, 16'h0001);
        conv_sample = 8'h10;
        wait_lvl(SSL_LOAD_HIGH, SAMPLE_CYC + 4, n);
        repeat (2 * TICK_CYC + 10) @(negedge ref_clk);
        chk_lvl("high idle", SSL_LOAD_HIGH, lvl);
        chk_word("high idle code", 16'h00AA, {6'h00, code});
        conv_sample = 8'h00;
        wait_lvl(SSL_LOAD_OFF, SAMPLE_CYC + 4, n);
        chk_lvl("zero high idle", SSL_LOAD_OFF, lvl);
        $display("test load done");
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        arst_n = 1'b0;
        dev_locked = 1'b0;
        conv_sample = 8'h00;
        dec_factor = 4'h0;
        src = 16'h0000;
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        t_reset();
        t_live();
        t_regs();
        t_load();
        wrap_up();
    end
endmodule
